// ==== hdl/serial_host_port.sv ====
/*
   Serial host port with select line, register file, status flags,
   receive word buffer and direct-mode pin routing.
   Assumes host serial clock far slower than clk (three-stage sampling);
   air-side events and words arrive on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_host_port
   import host_port_pkg::*;
(
   input  wire logic       clk,          // 200 MHz system clock
   input  wire logic       reset,        // Synchronous, active high
   input  wire logic       selectPin,    // Select, high = idle
   input  wire logic       sclkPin,      // Host serial clock
   input  wire logic       mosiPin,      // Host data in
   output logic            misoOut,      // Device data out
   output logic            misoOe,       // MISO drive enable
   output logic            irqOut,       // Interrupt, active high
   input  wire logic       modulationInput, // Direct modulation pin
   input  wire logic       keyingSelectPin, // 0 ASK, 1 OOK
   input  wire logic       envelopeIn,   // Digitized subcarrier
   input  wire logic       decodedBitIn, // Decoder bit stream
   input  wire logic       decodedClkIn, // Decoder bit clock
   input  wire logic       frameModIn,   // Modulation from framer
   input  wire logic       txDoneIn,     // Transmit complete pulse
   input  wire logic       rxStartIn,    // Receive start pulse
   input  wire logic [7:0] rxWordData,   // Received byte
   input  wire logic       rxWordDelim,  // Byte is a delimiter
   input  wire logic       rxWordValid,  // Received byte valid
   output logic            rxWordReady,  // Buffer can take byte
   output logic            modulatorOut, // Modulator drive
   output logic            rxDirectOut,  // Direct receive pin
   output logic            bitClockOut,  // Direct bit clock pin
   output logic            keyingOut,    // Keying in use
   output logic [2:0]      depthCode,    // Modulation depth
   output logic [1:0]      sysClkSel,    // System clock select
   output logic [2:0]      protocolKind, // Decoded protocol
   output logic            directActive  // Direct mode on
);
   localparam logic [7:0] SYNC_RST = 8'h01;
   logic [7:0] pinsSync;
   logic selS, sclkS, mosiS, modS, keyS, envS, dbitS, dclkS;
   pin_sync #(.W(8), .RESET_VAL(SYNC_RST)) syncPins (
      .clk    (clk),
      .reset  (reset),
      .pinIn  ({mosiPin, sclkPin, modulationInput, keyingSelectPin,
                envelopeIn, decodedBitIn, decodedClkIn, selectPin}),
      .pinOut (pinsSync)
   );
   assign {mosiS, sclkS, modS, keyS, envS, dbitS, dclkS, selS} = pinsSync;

   function automatic logic [2:0] protoDecode(input logic [7:0] v);
      case (v)
         PS_VICINITY_HDR: protoDecode = PK_VICINITY;
         PS_TYPEA_106:    protoDecode = PK_TYPEA;
         PS_PROP_212:     protoDecode = PK_PROP212;
         PS_PROP_424:     protoDecode = PK_PROP424;
         default:         protoDecode = PK_OTHER;
      endcase
   endfunction

   function automatic logic [2:0] depthDecode(input logic [2:0] v);
      case (v)
         3'h0:    depthDecode = DEPTH_ASK10;
         3'h1:    depthDecode = DEPTH_OOK;
         3'h2:    depthDecode = DEPTH_ASK7;
         3'h3:    depthDecode = DEPTH_ASK85;
         3'h4:    depthDecode = DEPTH_ASK13;
         3'h5:    depthDecode = DEPTH_ASK16;
         default: depthDecode = DEPTH_ASK10;
      endcase
   endfunction

   logic       sclkPrev_q, selPrev_q;
   logic [2:0] bitCnt_q;
   logic [7:0] rxShift_q, txShift_q;
   logic [4:0] addr_q;
   logic       cont_q, irqArm_q;
   phase_type  phase_q;
   logic [7:0] chipStatus_q, protoSel_q, noRespWait_q, rxWait_q;
   logic [7:0] modCtrl_q, rxSpecial_q, irqStatus_q, irqStatus_d;

   // Edges come from filtered levels, so glitches cannot double-count
   wire sclkRise = sclkS & ~sclkPrev_q;
   wire sclkFall = ~sclkS & sclkPrev_q;
   wire stopEvt = selS & ~selPrev_q;
   wire byteDone = sclkFall & ~selS & (bitCnt_q == BIT_LAST);
   wire [7:0] rxByte = {rxShift_q[6:0], mosiS};
   wire inCmd = (phase_q == PH_CMD);
   wire cmdDone = byteDone & inCmd & ~rxByte[CMD_BIT];
   wire directOn = chipStatus_q[DIRECT_BIT];
   wire dm0 = directOn & ~protoSel_q[DIRECT_BIT];
   wire dm1 = directOn & protoSel_q[DIRECT_BIT];
   wire [4:0] addrStep = cont_q ? addr_q + 5'h01 : addr_q;
   wire rdStart = cmdDone & rxByte[READ_BIT];
   wire readLoad = rdStart | (byteDone & (phase_q == PH_RD));
   wire [4:0] loadAddr = inCmd ? rxByte[ADDR_W-1:0] : addrStep;
   wire wrDone = byteDone & (phase_q == PH_WR) & ~dm0;
   wire wrChip = wrDone & (addr_q == ADR_CHIP_STATUS);
   wire wrProto = wrDone & (addr_q == ADR_PROTO_SEL);
   wire wrNoResp = wrDone & (addr_q == ADR_NORESP_WAIT);
   wire wrRxWait = wrDone & (addr_q == ADR_RX_WAIT);
   wire wrMod = wrDone & (addr_q == ADR_MODULATOR);
   wire wrSpecial = wrDone & (addr_q == ADR_RX_SPECIAL);
   // No status clear while direct mode 0 shuts the host out
   wire irqClr = irqArm_q & byteDone & ~dm0;

   word_stream_if #(.W(9)) fillIf ();
   word_stream_if #(.W(9)) drainIf ();
   word_buffer #(.W(9), .DEPTH(FIFO_DEPTH)) rxBuf (
      .clk   (clk),
      .reset (reset),
      .fill  (fillIf),
      .drain (drainIf)
   );
   assign fillIf.data = {rxWordDelim, rxWordData};
   assign fillIf.valid = rxWordValid & ~dm0;
   assign rxWordReady = fillIf.ready;
   // Delimiter words are stripped outside direct mode
   wire fifoDelim = drainIf.valid & drainIf.data[8] & ~directOn;
   wire fifoRead = readLoad & (loadAddr == ADR_FIFO) & ~dm0;
   assign drainIf.ready = fifoDelim | (fifoRead & ~drainIf.data[8]);
   wire [7:0] fifoByte = (drainIf.valid & ~fifoDelim) ?
                         drainIf.data[7:0] : RST_REG;

   logic [7:0] readData;
   always_comb
   begin
      case (loadAddr)
         ADR_CHIP_STATUS: readData = chipStatus_q;
         ADR_PROTO_SEL:   readData = protoSel_q;
         ADR_NORESP_WAIT: readData = noRespWait_q;
         ADR_RX_WAIT:     readData = rxWait_q;
         ADR_MODULATOR:   readData = modCtrl_q;
         ADR_RX_SPECIAL:  readData = rxSpecial_q;
         ADR_IRQ_STATUS:  readData = irqStatus_q;
         ADR_FIFO:        readData = fifoByte;
         default:         readData = RST_REG;
      endcase
      if (dm0)
         readData = RST_REG;
   end

   // New events win over the dummy-byte clear; none in direct mode
   always_comb
   begin
      irqStatus_d = irqClr ? RST_REG : irqStatus_q;
      irqStatus_d[IRQ_TX_BIT] = irqStatus_d[IRQ_TX_BIT]
                                | (txDoneIn & ~directOn);
      irqStatus_d[IRQ_RX_BIT] = irqStatus_d[IRQ_RX_BIT]
                                | (rxStartIn & ~directOn);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sclkPrev_q <= 1'b0;
         selPrev_q  <= 1'b1;
      end
      else
      begin
         sclkPrev_q <= sclkS;
         selPrev_q  <= selS;
      end
   end

   // Serial engine, held idle while select is high
   always_ff @(posedge clk)
   begin
      if (reset | selS)
      begin
         bitCnt_q  <= BIT_FIRST;
         rxShift_q <= RST_REG;
         txShift_q <= RST_REG;
         phase_q   <= PH_CMD;
         addr_q    <= '0;
         cont_q    <= 1'b0;
         irqArm_q  <= 1'b0;
      end
      else
      begin
         if (sclkFall)
         begin
            bitCnt_q  <= bitCnt_q + 3'h1;
            rxShift_q <= rxByte;
         end
         if (cmdDone)
         begin
            phase_q <= rxByte[READ_BIT] ? PH_RD : PH_WR;
            cont_q  <= rxByte[CONT_BIT];
         end
         if (readLoad)
            txShift_q <= readData;
         else if (sclkRise & (phase_q == PH_RD))
            txShift_q <= {txShift_q[6:0], 1'b0};
         if (cmdDone)
            addr_q <= rxByte[ADDR_W-1:0];
         else if (readLoad | (byteDone & (phase_q == PH_WR)))
            addr_q <= addrStep;
         if (readLoad)
            irqArm_q <= (loadAddr == ADR_IRQ_STATUS);
         else if (irqClr)
            irqArm_q <= 1'b0;
      end
   end

   // MISO moves on rising edges only while selected, so it is steady at falls
   always_ff @(posedge clk)
   begin
      if (reset | selS)
         misoOut <= 1'b0;
      else if (sclkRise)
         misoOut <= (phase_q == PH_RD) & txShift_q[7];
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         chipStatus_q <= RST_REG;
         protoSel_q   <= RST_REG;
         noRespWait_q <= RST_REG;
         rxWait_q     <= RST_REG;
         modCtrl_q    <= RST_REG;
         rxSpecial_q  <= RST_REG;
         irqStatus_q  <= RST_REG;
      end
      else
      begin
         if (stopEvt)
            chipStatus_q[DIRECT_BIT] <= 1'b0;
         else if (wrChip)
            chipStatus_q <= rxByte;
         if (wrProto)
            protoSel_q <= rxByte;
         if (wrNoResp)
            noRespWait_q <= rxByte;
         if (wrRxWait)
            rxWait_q <= rxByte;
         if (wrMod)
            modCtrl_q <= rxByte;
         if (wrSpecial)
            rxSpecial_q <= rxByte;
         irqStatus_q <= irqStatus_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         misoOe       <= 1'b0;
         irqOut       <= 1'b0;
         modulatorOut <= 1'b0;
         rxDirectOut  <= 1'b0;
         bitClockOut  <= 1'b0;
         keyingOut    <= 1'b0;
         depthCode    <= DEPTH_ASK10;
         sysClkSel    <= 2'h0;
         protocolKind <= PK_OTHER;
         directActive <= 1'b0;
      end
      else
      begin
         misoOe       <= ~selS;
         irqOut       <= |irqStatus_d;
         modulatorOut <= directOn ? modS : frameModIn;
         // Decoder output keeps its delimiters in direct mode 1
         rxDirectOut  <= dm0 ? envS : (dm1 & dbitS);
         bitClockOut  <= dm1 & dclkS;
         keyingOut    <= keyS;
         depthCode    <= keyS ? DEPTH_OOK : depthDecode(modCtrl_q[2:0]);
         sysClkSel    <= modCtrl_q[CLKSEL_LSB +: 2];
         protocolKind <= protoDecode(protoSel_q);
         directActive <= directOn;
      end
   end

   AST_SEL_RESET: assert property (@(posedge clk) disable iff (reset)
      selS |=> (bitCnt_q == BIT_FIRST) && (phase_q == PH_CMD))
      else $error("serial logic not idle under select");
   AST_BYTE_WRAP: assert property (@(posedge clk) disable iff (reset)
      byteDone |=> (bitCnt_q == BIT_FIRST))
      else $error("byte not eight bits");
   AST_MISO_RISE: assert property (@(posedge clk) disable iff (reset)
      !$stable(misoOut) |-> $past(sclkRise) || $past(selS))
      else $error("MISO moved off a rising edge");
   AST_MISO_IDLE: assert property (@(posedge clk) disable iff (reset)
      (phase_q != PH_RD) && sclkRise |=> !misoOut)
      else $error("MISO driven outside read phase");
   AST_ADDR_STEP: assert property (@(posedge clk) disable iff (reset)
      readLoad && !inCmd && cont_q |=> addr_q == $past(addr_q) + 5'h01)
      else $error("continuous read did not advance");
   AST_TX_IRQ: assert property (@(posedge clk) disable iff (reset)
      txDoneIn && !directOn |=> irqStatus_q[IRQ_TX_BIT] && irqOut)
      else $error("transmit done not flagged");
   AST_ENTER: assert property (@(posedge clk) disable iff (reset)
      wrChip && rxByte[DIRECT_BIT] && !stopEvt |=> ##1 directActive)
      else $error("direct mode not entered");
   AST_STOP: assert property (@(posedge clk) disable iff (reset)
      stopEvt |=> !chipStatus_q[DIRECT_BIT] ##1 !directActive)
      else $error("stop did not end direct mode");
   AST_DM0_LOCK: assert property (@(posedge clk) disable iff (reset)
      dm0 && byteDone |=> $stable(protoSel_q) && $stable(modCtrl_q))
      else $error("register written in direct mode 0");
   AST_DM0_ROUTE: assert property (@(posedge clk) disable iff (reset)
      dm0 |=> rxDirectOut == $past(envS) && !bitClockOut)
      else $error("envelope not routed in direct mode 0");
   AST_DM1_ROUTE: assert property (@(posedge clk) disable iff (reset)
      dm1 |=> bitClockOut == $past(dclkS))
      else $error("bit clock not routed in direct mode 1");
   AST_KEYING: assert property (@(posedge clk) disable iff (reset)
      keyS ##1 keyS |-> keyingOut && depthCode == DEPTH_OOK)
      else $error("on-off keying not applied");
endmodule
`default_nettype wire

// ==== hdl/host_port_pkg.sv ====
/*
   Shared constants of the serial host port with direct mode.
   Assumes a single 200 MHz system clock and a synchronous reset.
*/
// What this block does
// - Select high holds serial logic in reset
// - Host drives on rise, device samples fall
// - Select rising ends the transaction
// - Words are eight bits, MSB first
// - MISO carries nothing valid during command/write
// - Read data follows eighth falling edge, MSB first
// - Transmit done raises interrupt outside direct mode, status reads 0x80
// - Direct mode 0: raw modulation and envelope
// - Direct mode 1: decoded bits and bit clock
// - Writing direct bit at 0x00 enters direct
// - Stop condition ends direct, clears bit
// - Direct mode 0 blocks register access
// - Bypass framing keeps start/end delimiters
// - Raw-byte mode strips delimiters into FIFO
// - Protocol select codes decoded to protocol kind
// - Modulator codes decoded to depth, clock
// - Keying pin: 0 amplitude, 1 on-off
package host_port_pkg;
   localparam int WORD_W = 8;
   localparam int ADDR_W = 5;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   // Address word fields
   localparam int CMD_BIT = 7;
   localparam int READ_BIT = 6;
   localparam int CONT_BIT = 5;
   // Register offsets
   localparam logic [4:0] ADR_CHIP_STATUS = 5'h00;
   localparam logic [4:0] ADR_PROTO_SEL = 5'h01;
   localparam logic [4:0] ADR_NORESP_WAIT = 5'h07;
   localparam logic [4:0] ADR_RX_WAIT = 5'h08;
   localparam logic [4:0] ADR_MODULATOR = 5'h09;
   localparam logic [4:0] ADR_RX_SPECIAL = 5'h0A;
   localparam logic [4:0] ADR_IRQ_STATUS = 5'h0C;
   localparam logic [4:0] ADR_FIFO = 5'h1F;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam int DIRECT_BIT = 6;
   localparam int IRQ_TX_BIT = 7;
   localparam int IRQ_RX_BIT = 6;
   // Protocol select codes
   localparam logic [7:0] PS_VICINITY_HDR = 8'h02;
   localparam logic [7:0] PS_TYPEA_106 = 8'h08;
   localparam logic [7:0] PS_PROP_212 = 8'h1A;
   localparam logic [7:0] PS_PROP_424 = 8'h1B;
   localparam logic [2:0] PK_OTHER = 3'h0;
   localparam logic [2:0] PK_VICINITY = 3'h1;
   localparam logic [2:0] PK_TYPEA = 3'h2;
   localparam logic [2:0] PK_PROP212 = 3'h3;
   localparam logic [2:0] PK_PROP424 = 3'h4;
   // Modulator: system clock field and depth codes
   localparam int CLKSEL_LSB = 4;
   localparam logic [2:0] DEPTH_ASK10 = 3'h0;
   localparam logic [2:0] DEPTH_OOK = 3'h1;
   localparam logic [2:0] DEPTH_ASK7 = 3'h2;
   localparam logic [2:0] DEPTH_ASK85 = 3'h3;
   localparam logic [2:0] DEPTH_ASK13 = 3'h4;
   localparam logic [2:0] DEPTH_ASK16 = 3'h5;
   localparam int FIFO_DEPTH = 2;
   typedef enum logic [2:0]
   {
      PH_CMD = 3'b001,
      PH_WR  = 3'b010,
      PH_RD  = 3'b100
   } phase_type;
endpackage

// ==== hdl/word_stream_if.sv ====
/*
   Valid/ready word stream between the port and its buffer.
   Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int W = 9);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== hdl/pin_sync.sv ====
/*
   Three-stage pin synchroniser with agreement filter.
   Assumes asynchronous pins; output moves when stages 2 and 3 agree.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         clk,     // System clock
   input  wire logic         reset,   // Synchronous reset
   input  wire logic [W-1:0] pinIn,   // Raw pins
   output logic      [W-1:0] pinOut   // Filtered levels
);
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage2_q;
   logic [W-1:0] stage3_q;
   logic [W-1:0] agree;
   assign agree = ~(stage2_q ^ stage3_q);
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         stage1_q <= RESET_VAL;
         stage2_q <= RESET_VAL;
         stage3_q <= RESET_VAL;
         pinOut   <= RESET_VAL;
      end
      else
      begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         pinOut   <= (agree & stage3_q) | (~agree & pinOut);
      end
   end
endmodule
`default_nettype wire

// ==== hdl/word_buffer.sv ====
/*
   Small valid/ready word buffer, default two entries.
   Assumes one clock; in-side ready is registered.
*/
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
   parameter int W = 9,
   parameter int DEPTH = 2
) (
   input  wire logic   clk,       // System clock
   input  wire logic   reset,     // Synchronous reset
   word_stream_if.snk  fill,      // Filling side
   word_stream_if.src  drain      // Draining side
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic          push;
   logic          pop;
   logic          ready_q;
   assign push = fill.valid & ready_q;
   assign pop = drain.ready & (count_q != '0);
   assign count_d = count_q + CW'(push) - CW'(pop);
   assign fill.ready = ready_q;
   assign drain.valid = (count_q != '0);
   assign drain.data = mem_q[rdPtr_q];
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         ready_q <= 1'b1;
      end
      else
      begin
         if (push)
         begin
            mem_q[wrPtr_q] <= fill.data;
            wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1;
         end
         if (pop)
            rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1;
         count_q <= count_d;
         ready_q <= (count_d != FULL);
      end
   end
endmodule
`default_nettype wire

// ==== test/host_model.sv ====
/*
   Host side of the serial link: select, serial clock, data out.
   Assumes clk is the device clock; half a serial period is 16 clk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic clk,        // Device clock, paces the steps
   output logic      selectPin,  // Select, high = idle
   output logic      sclkPin,    // Serial clock, still outside frames
   output logic      mosiPin,    // Host data
   input  wire logic misoOut     // Device data
);
   initial
   begin
      selectPin = 1'b1;
      sclkPin = 1'b0;
      mosiPin = 1'b0;
   end
   task automatic half();
      repeat (16) @(posedge clk);
      #1;
   endtask
   task automatic sel(input logic lvl);
      half();
      selectPin = lvl;
      // Released data line must not keep its last bit
      if (lvl)
         mosiPin = ~mosiPin;
      half();
   endtask
   // Shifts n bits MSB first; n below 8 is a deliberate broken word
   task automatic shift(input int n, input logic [7:0] tx,
                        output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         sclkPin = 1'b1;
         mosiPin = tx[i];
         half();
         rx[i] = misoOut;
         sclkPin = 1'b0;
         half();
      end
   endtask
endmodule
`default_nettype wire

// ==== test/tb_serial_host_port.sv ====
/*
   Self-checking bench of the serial host port.
   Assumes host_model on the link and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_serial_host_port;
   import host_port_pkg::*;
   logic       clk, reset, selectPin, sclkPin, mosiPin, misoOut, misoOe;
   logic       irqOut, modulationInput, keyingSelectPin, envelopeIn;
   logic       decodedBitIn, decodedClkIn, frameModIn, txDoneIn, rxStartIn;
   logic [7:0] rxWordData, b0, b1;
   logic       rxWordDelim, rxWordValid, rxWordReady, modulatorOut;
   logic       rxDirectOut, bitClockOut, keyingOut, directActive, took;
   logic [2:0] depthCode, protocolKind;
   logic [1:0] sysClkSel;
   int         failCount = 0;
   int         checksDone = 0;
   localparam logic [7:0] PROTO [5] = '{8'h02, 8'h08, 8'h1A, 8'h1B, 8'h05};
   localparam logic [2:0] KIND [5] = '{PK_VICINITY, PK_TYPEA, PK_PROP212,
      PK_PROP424, PK_OTHER};
   localparam logic [4:0] REGS [6] = '{ADR_CHIP_STATUS, ADR_PROTO_SEL,
      ADR_NORESP_WAIT, ADR_RX_WAIT, ADR_MODULATOR, ADR_RX_SPECIAL};
   localparam logic [7:0] VALS [4] = '{8'h0E, 8'h07, 8'h21, 8'h20};
   localparam logic [2:0] DEPTH [6] = '{DEPTH_ASK10, DEPTH_OOK, DEPTH_ASK7,
      DEPTH_ASK85, DEPTH_ASK13, DEPTH_ASK16};

   serial_host_port i_serial_host_port (.clk, .reset, .selectPin, .sclkPin,
      .mosiPin, .misoOut, .misoOe, .irqOut, .modulationInput,
      .keyingSelectPin, .envelopeIn, .decodedBitIn, .decodedClkIn,
      .frameModIn, .txDoneIn, .rxStartIn, .rxWordData, .rxWordDelim,
      .rxWordValid, .rxWordReady, .modulatorOut, .rxDirectOut, .bitClockOut,
      .keyingOut, .depthCode, .sysClkSel, .protocolKind, .directActive);
   host_model i_host_model (.clk, .selectPin, .sclkPin, .mosiPin, .misoOut);

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         failCount++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Order: modulation, keying, envelope, bit, bit clock, framer
   task automatic drive(input logic [5:0] v);
      {modulationInput, keyingSelectPin, envelopeIn, decodedBitIn,
       decodedClkIn, frameModIn} = v;
   endtask
   task automatic wr(input logic [7:0] aw, input logic [7:0] d);
      logic [7:0] r;
      i_host_model.sel(1'b0);
      i_host_model.shift(8, aw, r);
      check(r, 8'h00);
      check({7'h00, misoOe}, 8'h01);
      i_host_model.shift(8, d, r);
      i_host_model.sel(1'b1);
   endtask
   // Status clears as the first read byte ends; with the continuous bit set the second byte does not clear it
   task automatic rd2(input logic [7:0] aw, output logic [7:0] d0,
                      output logic [7:0] d1);
      logic [7:0] r;
      i_host_model.sel(1'b0);
      i_host_model.shift(8, aw, r);
      i_host_model.shift(8, 8'h00, d0);
      i_host_model.shift(8, 8'h00, d1);
      i_host_model.sel(1'b1);
   endtask
   task automatic push(input logic [7:0] d, input logic dl, input logic exp);
      rxWordData = d;
      rxWordDelim = dl;
      rxWordValid = 1'b1;
      took = 1'b0;
      // Ready is settled here; the coming edge takes the word
      for (int n = 0; n < 20 && !took; n++)
      begin
         took = rxWordReady;
         tick(1);
      end
      check({7'h00, took}, {7'h00, exp});
      if (exp && !took)
         complete_run();
   endtask
   task automatic evt(input logic tx, input logic [7:0] exp);
      logic [7:0] r;
      {txDoneIn, rxStartIn} = {tx, ~tx};
      tick(1);
      {txDoneIn, rxStartIn} = 2'b00;
      tick(2);
      check({7'h00, irqOut}, {7'h00, |exp});
      if (|exp)
      begin
         rd2({3'b011, ADR_IRQ_STATUS}, r, b1);
         check(r, exp);
         check({7'h00, irqOut}, 8'h00);
      end
   endtask
   // Leaves select low: a stop would end direct mode at once
   task automatic enter(input logic [7:0] ps, input logic [7:0] extra);
      logic [7:0] r;
      wr({3'b000, ADR_MODULATOR}, 8'h61);
      wr({3'b000, ADR_PROTO_SEL}, ps);
      i_host_model.sel(1'b0);
      i_host_model.shift(8, {3'b000, ADR_CHIP_STATUS}, r);
      i_host_model.shift(8, 8'h40, r);
      i_host_model.shift(8, extra, r);
      tick(8);
      check({7'h00, directActive}, 8'h01);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      #400000;
      failCount++;
      complete_run();
   end
   initial
   begin
      reset = 1'b1;
      drive(6'h00);
      {txDoneIn, rxStartIn} = 2'b00;
      {rxWordDelim, rxWordValid} = 2'b00;
      rxWordData = 8'h00;
      repeat (12) @(posedge clk);
      #1;
      reset = 1'b0;
      foreach (REGS[i])
      begin
         rd2({3'b010, REGS[i]}, b0, b1);
         check(b0, RST_REG);
      end
      i_host_model.sel(1'b0);
      i_host_model.shift(8, {3'b001, ADR_NORESP_WAIT}, b0);
      foreach (VALS[i])
         i_host_model.shift(8, VALS[i], b0);
      i_host_model.sel(1'b1);
      i_host_model.sel(1'b0);
      i_host_model.shift(8, {3'b011, ADR_NORESP_WAIT}, b0);
      foreach (VALS[i])
      begin
         i_host_model.shift(8, 8'h00, b0);
         check(b0, VALS[i]);
      end
      i_host_model.sel(1'b1);
      $display("Done: registers and continuous access");
      foreach (PROTO[i])
      begin
         wr({3'b000, ADR_PROTO_SEL}, PROTO[i]);
         check({5'h00, protocolKind}, {5'h00, KIND[i]});
      end
      foreach (DEPTH[i])
      begin
         wr({3'b000, ADR_MODULATOR}, 8'h20 + 8'(i));
         check({5'h00, depthCode}, {5'h00, DEPTH[i]});
         check({6'h00, sysClkSel}, 8'h02);
      end
      drive(6'h11);
      tick(8);
      check({5'h00, depthCode}, {5'h00, DEPTH_OOK});
      check({7'h00, keyingOut}, 8'h01);
      check({7'h00, modulatorOut}, 8'h01);
      drive(6'h00);
      $display("Done: protocol and modulator decode");
      evt(1'b1, 8'h80);
      evt(1'b0, 8'h40);
      $display("Done: status events");
      push(8'hA1, 1'b0, 1'b1);
      push(8'hB2, 1'b0, 1'b1);
      push(8'hC3, 1'b0, 1'b0);
      rxWordValid = 1'b0;
      rd2({3'b010, ADR_FIFO}, b0, b1);
      check(b0, 8'hA1);
      check(b1, 8'hB2);
      push(8'hC3, 1'b0, 1'b1);
      push(8'hD4, 1'b1, 1'b1);
      rxWordValid = 1'b0;
      rd2({3'b010, ADR_FIFO}, b0, b1);
      check(b0, 8'hC3);
      check(b1, 8'h00);
      $display("Done: receive buffer");
      i_host_model.sel(1'b0);
      i_host_model.shift(4, {3'b000, ADR_PROTO_SEL}, b0);
      i_host_model.sel(1'b1);
      wr({3'b000, ADR_PROTO_SEL}, 8'h08);
      rd2({3'b010, ADR_PROTO_SEL}, b0, b1);
      check(b0, 8'h08);
      $display("Done: broken word discarded");
      enter(8'h00, 8'h00);
      drive(6'h2A);
      tick(8);
      check({6'h00, modulatorOut, rxDirectOut}, 8'h03);
      check({7'h00, bitClockOut}, 8'h00);
      evt(1'b1, 8'h00);
      i_host_model.sel(1'b1);
      check({7'h00, directActive}, 8'h00);
      check({6'h00, modulatorOut, rxDirectOut}, 8'h00);
      check({7'h00, misoOe}, 8'h00);
      rd2({3'b010, ADR_CHIP_STATUS}, b0, b1);
      check(b0, 8'h00);
      rd2({3'b010, ADR_IRQ_STATUS}, b0, b1);
      check(b0, 8'h00);
      $display("Done: direct mode 0");
      enter(8'h48, 8'h40);
      drive(6'h26);
      tick(8);
      check({6'h00, rxDirectOut, bitClockOut}, 8'h03);
      i_host_model.sel(1'b1);
      check({7'h00, directActive}, 8'h00);
      $display("Done: direct mode 1");
      complete_run();
   end
endmodule
`default_nettype wire
